//--- verilog/i2c_link_pkg.sv
// Shared constants for the two-wire register link
package i2c_link_pkg;
  // Addressing
  localparam logic [6:0] SLAVE_ADDR     = 7'h29;
  localparam logic       DIR_READ       = 1'b1;
  localparam logic       DIR_WRITE      = 1'b0;
  // Register file
  localparam int         NUM_REGS       = 32;
  localparam logic [7:0] RESET_REG_ADDR = 8'h14;
  localparam logic [7:0] RESET_KEY      = 8'hff;
  localparam logic [7:0] REG_DEFAULT    = 8'h00;
  // Framing
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
  localparam logic [1:0] FIFO_DEPTH     = 2'h2;
  // Timing of the master's clock
  localparam int         CLK_PERIOD_NS  = 4;
  localparam int         SCL_PERIOD_NS  = 2500;
  localparam int         SCL_QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
endpackage

//--- verilog/i2c_link_if.sv
// Open-drain two-wire link joining master and register slave
`timescale 1ns/1ns
interface i2c_link_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Pull-ups win unless an enabled driver shows low
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport device (
    input  scl,
    input  sda,
    output dev_sda_o,
    output dev_sda_oe
  );

  modport host (
    input  scl,
    input  sda,
    output host_scl_o,
    output host_scl_oe,
    output host_sda_o,
    output host_sda_oe
  );
endinterface

//--- verilog/i2c_reg_slave.sv
// Register slave end of the two-wire link
// How it works
// - SDA change during SCL high aborts transfer
// - Bytes are eight bits, MSB first
// - Detect start and stop while SCL high
// - Only master makes start and stop
// - Busy from start to stop; repeated start readdresses
// - Receiver holds SDA low during ninth clock
// - Transmitter releases SDA for acknowledge clock
// - Master NACKs last read byte
// - Acknowledge only address 0x29
// - Eighth bit selects read or write
// - Write carries register address then data
// - Pointer steps after each written byte
// - Master ends write with stop
// - Read needs address write then repeated start
// - Read sends bytes, stepping on master ACK
// - NACK then stop ends read, SDA released
// - Enable pin low disables and resets registers
// - Writing FFh to 0x14 resets registers
`timescale 1ns/1ns
module i2c_reg_slave #(
  parameter int NUM_REGS = i2c_link_pkg::NUM_REGS
) (
  // Clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  sys_rst_i,
  // Hardware enable pin, asynchronous
  input  wire logic                  hw_enable_n_i,
  // Two-wire link
  i2c_link_if.device                 link,
  // Register contents and bus state
  output logic [NUM_REGS*8-1:0]      regs_o,
  output logic                       busy_o,
  // Stream of written bytes
  output logic                       wr_valid_o,
  input  wire logic                  wr_ready_i,
  output logic [7:0]                 wr_addr_o,
  output logic [7:0]                 wr_data_o
);

  // Pointer must reach the reset register and stay byte wide
  if (NUM_REGS <= int'(i2c_link_pkg::RESET_REG_ADDR) || NUM_REGS > 256)
  begin : g_bad_regs
    $error("NUM_REGS out of range");
  end

  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_RECV   = 6'b000010,
    ST_ACK    = 6'b000100,
    ST_SEND   = 6'b001000,
    ST_MACK   = 6'b010000,
    ST_IGNORE = 6'b100000
  } state_type;

  typedef enum logic [2:0] {
    PH_ADDR = 3'b001,
    PH_REG  = 3'b010,
    PH_DATA = 3'b100
  } phase_type;

  typedef struct packed {
    state_type                state;
    phase_type                phase;
    logic [2:0]               scl_sync;
    logic [2:0]               sda_sync;
    logic [1:0]               en_sync;
    logic                     busy;
    logic                     read_dir;
    logic                     acking;
    logic                     mack;
    logic [3:0]               cnt;
    logic [7:0]               shift;
    logic [7:0]               ptr;
    logic                     sda_oe;
    logic [NUM_REGS-1:0][7:0] regs;
    logic [1:0]               fifo_cnt;
    logic [1:0][15:0]         fifo;
  } slave_state_type;

  localparam slave_state_type RESET_STATE = '{
    state:    ST_IDLE,
    phase:    PH_ADDR,
    scl_sync: 3'h7,
    sda_sync: 3'h7,
    en_sync:  2'h0, // Disabled until the pin is seen high
    regs:     {NUM_REGS{i2c_link_pkg::REG_DEFAULT}},
    default:  '0
  };

  slave_state_type r_reg;
  slave_state_type r_next;
  logic            scl_now;
  logic            scl_prev;
  logic            sda_now;
  logic            sda_prev;
  logic            scl_rise;
  logic            scl_fall;
  logic            start_seen;
  logic            stop_seen;

  // Byte for a read; unmapped addresses read as zero
  function automatic logic [7:0] read_byte(input slave_state_type s, input logic [7:0] p);
    read_byte = 8'h00;
    if (int'(p) < NUM_REGS)
    begin
      read_byte = s.regs[p];
    end
  endfunction

  // Edges seen on the second and third sampling stages only
  assign scl_now    = r_reg.scl_sync[1];
  assign scl_prev   = r_reg.scl_sync[2];
  assign sda_now    = r_reg.sda_sync[1];
  assign sda_prev   = r_reg.sda_sync[2];
  assign scl_rise   = scl_now & ~scl_prev;
  assign scl_fall   = ~scl_now & scl_prev;
  assign start_seen = scl_now & scl_prev & sda_prev & ~sda_now;
  assign stop_seen  = scl_now & scl_prev & ~sda_prev & sda_now;

  // Next state of the whole slave
  always_comb
  begin
    r_next = r_reg;
    r_next.scl_sync = {r_reg.scl_sync[1:0], link.scl};
    r_next.sda_sync = {r_reg.sda_sync[1:0], link.sda};
    r_next.en_sync  = {r_reg.en_sync[0], hw_enable_n_i};

    // Drain side of the write buffer
    if (r_reg.fifo_cnt != 2'h0 && wr_ready_i)
    begin
      r_next.fifo[0]  = r_reg.fifo[1];
      r_next.fifo_cnt = r_reg.fifo_cnt - 2'h1;
    end

    // Any SDA change with SCL high is a start or stop and ends the transfer
    if (stop_seen)
    begin
      r_next.state  = ST_IDLE;
      r_next.busy   = 1'b0;
      r_next.sda_oe = 1'b0;
    end
    else if (start_seen)
    begin
      r_next.state  = ST_RECV;
      r_next.phase  = PH_ADDR;
      r_next.busy   = 1'b1;
      r_next.cnt    = 4'h0;
      r_next.sda_oe = 1'b0;
    end
    else
    begin
      case (r_reg.state)
        ST_RECV:
        begin
          if (scl_rise)
          begin
            r_next.shift = {r_reg.shift[6:0], sda_now};
            r_next.cnt   = r_reg.cnt + 4'h1;
          end
          else if (scl_fall && r_reg.cnt == i2c_link_pkg::BITS_PER_BYTE)
          begin
            r_next.state  = ST_ACK;
            r_next.acking = 1'b1;
            case (r_reg.phase)
              PH_ADDR:
              begin
                r_next.acking   = r_reg.shift[7:1] == i2c_link_pkg::SLAVE_ADDR;
                r_next.read_dir = r_reg.shift[0] == i2c_link_pkg::DIR_READ;
              end
              PH_REG:
              begin
                r_next.ptr = r_reg.shift;
              end
              default:
              begin
                // A full buffer refuses the byte with a NACK rather than lose it
                r_next.acking = r_reg.fifo_cnt < i2c_link_pkg::FIFO_DEPTH;
                if (r_next.acking)
                begin
                  if (int'(r_reg.ptr) < NUM_REGS)
                  begin
                    r_next.regs[r_reg.ptr] = r_reg.shift;
                  end
                  if (r_reg.ptr == i2c_link_pkg::RESET_REG_ADDR &&
                      r_reg.shift == i2c_link_pkg::RESET_KEY)
                  begin
                    r_next.regs = RESET_STATE.regs;
                  end
                  r_next.fifo[r_next.fifo_cnt[0]] = {r_reg.ptr, r_reg.shift};
                  r_next.fifo_cnt = r_next.fifo_cnt + 2'h1;
                end
              end
            endcase
            r_next.sda_oe = r_next.acking;
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            r_next.sda_oe = 1'b0;
            r_next.cnt    = 4'h0;
            r_next.state  = ST_RECV;
            if (!r_reg.acking)
            begin
              r_next.state = ST_IGNORE;
            end
            else if (r_reg.phase == PH_ADDR && r_reg.read_dir)
            begin
              r_next.state  = ST_SEND;
              r_next.shift  = read_byte(r_reg, r_reg.ptr);
              r_next.sda_oe = ~r_next.shift[7];
            end
            else if (r_reg.phase == PH_ADDR)
            begin
              r_next.phase = PH_REG;
            end
            else
            begin
              r_next.phase = PH_DATA;
              if (r_reg.phase == PH_DATA)
              begin
                r_next.ptr = r_reg.ptr + 8'h1;
              end
            end
          end
        end
        ST_SEND:
        begin
          if (scl_fall)
          begin
            if (r_reg.cnt == i2c_link_pkg::BITS_PER_BYTE - 4'h1)
            begin
              r_next.state  = ST_MACK;
              r_next.sda_oe = 1'b0;
            end
            else
            begin
              r_next.cnt    = r_reg.cnt + 4'h1;
              r_next.shift  = {r_reg.shift[6:0], 1'b0};
              r_next.sda_oe = ~r_reg.shift[6];
            end
          end
        end
        ST_MACK:
        begin
          if (scl_rise)
          begin
            r_next.mack = ~sda_now;
          end
          else if (scl_fall)
          begin
            if (r_reg.mack)
            begin
              r_next.ptr    = r_reg.ptr + 8'h1;
              r_next.shift  = read_byte(r_reg, r_next.ptr);
              r_next.cnt    = 4'h0;
              r_next.sda_oe = ~r_next.shift[7];
              r_next.state  = ST_SEND;
            end
            else
            begin
              r_next.state = ST_IGNORE;
            end
          end
        end
        ST_IDLE, ST_IGNORE:
        begin
          r_next.sda_oe = 1'b0;
        end
        default:
        begin
          r_next.state = ST_IDLE;
        end
      endcase
    end

    // Enable pin low holds everything at defaults; samplers keep running
    if (!r_reg.en_sync[1])
    begin
      r_next          = RESET_STATE;
      r_next.scl_sync = {r_reg.scl_sync[1:0], link.scl};
      r_next.sda_sync = {r_reg.sda_sync[1:0], link.sda};
      r_next.en_sync  = {r_reg.en_sync[0], hw_enable_n_i};
    end
  end

  // Single state register
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      r_reg <= RESET_STATE;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign regs_o          = r_reg.regs;
  assign busy_o          = r_reg.busy;
  assign wr_valid_o      = r_reg.fifo_cnt != 2'h0;
  assign wr_addr_o       = r_reg.fifo[0][15:8];
  assign wr_data_o       = r_reg.fifo[0][7:0];
  assign link.dev_sda_o  = 1'b0;
  assign link.dev_sda_oe = r_reg.sda_oe;

endmodule

//--- verilog/i2c_reg_master.sv
// Bus master end of the two-wire link: single-byte register access
`timescale 1ns/1ns
module i2c_reg_master #(
  parameter int QUARTER_CYC = i2c_link_pkg::SCL_QUARTER_CYC
) (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       sys_rst_i,
  // Two-wire link
  i2c_link_if.host        link,
  // Command port
  input  wire logic       cmd_valid_i,
  output logic            cmd_ready_o,
  input  wire logic       cmd_read_i,
  input  wire logic [7:0] cmd_reg_i,
  input  wire logic [7:0] cmd_data_i,
  // Response port
  output logic            rsp_valid_o,
  input  wire logic       rsp_ready_i,
  output logic [7:0]      rsp_data_o,
  output logic            rsp_nack_o
);

  if (QUARTER_CYC < 1 || QUARTER_CYC > 65535)
  begin : g_bad_div
    $error("QUARTER_CYC out of range");
  end

  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_START = 4'b0010,
    H_BITS  = 4'b0100,
    H_STOP  = 4'b1000
  } hstate_type;

  typedef struct packed {
    hstate_type state;
    logic [15:0] div;
    logic [1:0]  q;
    logic [3:0]  bitn;
    logic [1:0]  idx;
    logic        rd;
    logic [7:0]  reg_a;
    logic [7:0]  data;
    logic [7:0]  shift;
    logic [7:0]  rx;
    logic        ack_bad;
    logic [1:0]  sda_sync;
    logic        scl_low;
    logic        sda_low;
    logic        rsp_valid;
    logic [7:0]  rsp_data;
    logic        rsp_nack;
  } master_state_type;

  localparam master_state_type RESET_STATE = '{state: H_IDLE, default: '0};

  master_state_type r_reg;
  master_state_type r_next;
  logic             tick;

  // Byte sent in each step; read data slot transmits all ones to release SDA
  function automatic logic [7:0] tx_byte(input master_state_type s, input logic [1:0] i);
    case (i)
      2'h0:    tx_byte = {i2c_link_pkg::SLAVE_ADDR, i2c_link_pkg::DIR_WRITE};
      2'h1:    tx_byte = s.reg_a;
      2'h2:    tx_byte = s.rd ? {i2c_link_pkg::SLAVE_ADDR, i2c_link_pkg::DIR_READ} : s.data;
      default: tx_byte = 8'hff;
    endcase
  endfunction

  assign tick = r_reg.div == 16'(QUARTER_CYC - 1);

  // Each slot is four quarters: low, rise, high, fall
  always_comb
  begin
    r_next = r_reg;
    r_next.sda_sync = {r_reg.sda_sync[0], link.sda};
    r_next.div = tick ? 16'h0 : r_reg.div + 16'h1;
    if (r_reg.rsp_valid && rsp_ready_i)
    begin
      r_next.rsp_valid = 1'b0;
    end

    if (r_reg.state == H_IDLE)
    begin
      r_next.div = 16'h0;
      if (cmd_valid_i && !r_reg.rsp_valid)
      begin
        r_next.state   = H_START;
        r_next.q       = 2'h0; // Full start slot, so SDA falls while SCL is high
        r_next.idx     = 2'h0;
        r_next.rd      = cmd_read_i;
        r_next.reg_a   = cmd_reg_i;
        r_next.data    = cmd_data_i;
        r_next.ack_bad = 1'b0;
      end
    end
    else if (tick)
    begin
      r_next.q = r_reg.q + 2'h1;
      if (r_reg.q != 2'h3)
      begin
        case (r_next.q)
          2'h1:
          begin
            r_next.scl_low = 1'b0;
          end
          2'h2:
          begin
            if (r_reg.state == H_START)
            begin
              r_next.sda_low = 1'b1;
            end
            else if (r_reg.state == H_STOP)
            begin
              r_next.sda_low = 1'b0;
            end
            else if (r_reg.bitn == i2c_link_pkg::BITS_PER_BYTE)
            begin
              r_next.ack_bad = r_reg.sda_sync[1] & (r_reg.idx != 2'h3);
            end
            else
            begin
              r_next.rx = {r_reg.rx[6:0], r_reg.sda_sync[1]};
            end
          end
          default:
          begin
            r_next.scl_low = r_reg.state != H_STOP;
          end
        endcase
      end
      else
      begin
        // Slot boundary: choose the next slot and apply its first quarter
        case (r_reg.state)
          H_START:
          begin
            r_next.state   = H_BITS;
            r_next.bitn    = 4'h0;
            r_next.shift   = tx_byte(r_reg, r_reg.idx);
            r_next.sda_low = ~r_next.shift[7];
          end
          H_BITS:
          begin
            if (r_reg.bitn != i2c_link_pkg::BITS_PER_BYTE)
            begin
              // Ones fill in, so the ninth bit releases SDA or sends NACK
              r_next.bitn    = r_reg.bitn + 4'h1;
              r_next.shift   = {r_reg.shift[6:0], 1'b1};
              r_next.sda_low = ~r_next.shift[7];
            end
            else if (r_reg.ack_bad || r_reg.idx == 2'h3 || (r_reg.idx == 2'h2 && !r_reg.rd))
            begin
              r_next.state    = H_STOP;
              r_next.sda_low  = 1'b1;
              r_next.rsp_nack = r_reg.ack_bad;
            end
            else if (r_reg.idx == 2'h1 && r_reg.rd)
            begin
              r_next.state   = H_START;
              r_next.idx     = 2'h2;
              r_next.sda_low = 1'b0;
            end
            else
            begin
              r_next.idx     = r_reg.idx + 2'h1;
              r_next.bitn    = 4'h0;
              r_next.shift   = tx_byte(r_reg, r_next.idx);
              r_next.sda_low = ~r_next.shift[7];
            end
          end
          default:
          begin
            r_next.state     = H_IDLE;
            r_next.rsp_valid = 1'b1;
            r_next.rsp_data  = r_reg.rx;
          end
        endcase
      end
    end
  end

  // Single state register
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      r_reg <= RESET_STATE;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // Open drain: drive only lows
  assign link.host_scl_o  = 1'b0;
  assign link.host_scl_oe = r_reg.scl_low;
  assign link.host_sda_o  = 1'b0;
  assign link.host_sda_oe = r_reg.sda_low;
  assign cmd_ready_o      = r_reg.state == H_IDLE && !r_reg.rsp_valid;
  assign rsp_valid_o      = r_reg.rsp_valid;
  assign rsp_data_o       = r_reg.rsp_data;
  assign rsp_nack_o       = r_reg.rsp_nack;

endmodule

//--- tb/i2c_link_assertions.sv
// Protocol assertions on the link joining master and register slave
`timescale 1ns/1ns
module i2c_link_assertions (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  // Link signals
  input  wire logic host_scl_o,
  input  wire logic host_scl_oe,
  input  wire logic host_sda_o,
  input  wire logic host_sda_oe,
  input  wire logic dev_sda_o,
  input  wire logic dev_sda_oe,
  input  wire logic scl,
  input  wire logic sda
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  // Open drain: drivers only ever pull low
  AST_DEV_PULL_LOW: assert property (dev_sda_o == 1'b0)
    else $error("slave drives sda high");
  AST_HOST_PULL_LOW: assert property (!host_scl_o && !host_sda_o)
    else $error("master drives a line high");
  // Lines released as soon as reset lets go
  AST_IDLE_AFTER_RST: assert property ($fell(sys_rst_i) |-> !host_scl_oe && !host_sda_oe && !dev_sda_oe)
    else $error("line held after reset");
  // Slave low level held for eight cycles after the clock rises
  AST_ACK_HOLD: assert property ($rose(scl) && dev_sda_oe |=> dev_sda_oe [*8])
    else $error("slave let go during high clock");
  // Slave moves sda only shortly after a clock fall
  AST_DEV_EDGE: assert property ($changed(dev_sda_oe) |-> !scl && ($past(scl, 3) || $past(scl, 4)))
    else $error("slave sda change outside low clock");
  // Master lets go while the slave answers
  AST_HOST_RELEASE: assert property ($rose(scl) && dev_sda_oe |-> !host_sda_oe)
    else $error("master holds sda in slave slot");
  // After a stop the slave stays off the bus
  AST_STOP_QUIET: assert property (scl && $past(scl) && $rose(sda) |=> !dev_sda_oe [*8])
    else $error("slave drives after stop");
  // Start is made by the master alone
  AST_START_HOST: assert property (scl && $past(scl) && $fell(sda) |-> !dev_sda_oe && host_sda_oe)
    else $error("start not made by master");
  // Each bit has a full low phase
  AST_SCL_LOW_MIN: assert property ($fell(scl) |=> !scl [*8])
    else $error("clock low phase too short");

  // Main traffic seen
  cover property (scl && $past(scl) && $fell(sda));
  cover property (scl && $past(scl) && $rose(sda));
  cover property ($rose(scl) && dev_sda_oe);
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the two-wire register link
`timescale 1ns/1ns
module tb_top;
  localparam int Q = 8;
  localparam int BQ = 4; // Bench-made clock quarter: 4 cycles, 16 ns
  localparam int W = i2c_link_pkg::NUM_REGS * 8;
  logic         core_clk_i = 1'b0;
  logic         sys_rst_i  = 1'b1;
  logic         hw_en_n    = 1'b1;
  logic         wr_rdy     = 1'b0;
  logic         cmd_valid  = 1'b0;
  logic         cmd_read   = 1'b0;
  logic         rsp_ready  = 1'b0;
  logic [7:0]   cmd_reg    = 8'h00;
  logic [7:0]   cmd_data   = 8'h00;
  logic         cmd_ready, rsp_valid, rsp_nack, busy, wr_valid, busy_b, ack;
  logic [7:0]   rsp_data, wr_addr, wr_data, rd;
  logic [W-1:0] regs, regs_b;
  int           err_count  = 0;
  int           checked    = 0;
  int           cyc        = 0;

  i2c_link_if u_i2c_link_if ();
  i2c_link_if u_link_b ();

  i2c_reg_master #(.QUARTER_CYC(Q)) u_i2c_reg_master (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .link(u_i2c_link_if),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_read_i(cmd_read),
    .cmd_reg_i(cmd_reg), .cmd_data_i(cmd_data), .rsp_valid_o(rsp_valid),
    .rsp_ready_i(rsp_ready), .rsp_data_o(rsp_data), .rsp_nack_o(rsp_nack));
  i2c_reg_slave u_i2c_reg_slave (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .hw_enable_n_i(hw_en_n),
    .link(u_i2c_link_if), .regs_o(regs), .busy_o(busy), .wr_valid_o(wr_valid),
    .wr_ready_i(wr_rdy), .wr_addr_o(wr_addr), .wr_data_o(wr_data));
  // Second slave faces the bench, which breaks the rules on purpose
  i2c_reg_slave u_i2c_reg_slave_b (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .hw_enable_n_i(hw_en_n),
    .link(u_link_b), .regs_o(regs_b), .busy_o(busy_b), .wr_valid_o(),
    .wr_ready_i(wr_rdy), .wr_addr_o(), .wr_data_o());
  i2c_link_assertions u_i2c_link_assertions (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .host_scl_o(u_i2c_link_if.host_scl_o), .host_scl_oe(u_i2c_link_if.host_scl_oe),
    .host_sda_o(u_i2c_link_if.host_sda_o), .host_sda_oe(u_i2c_link_if.host_sda_oe),
    .dev_sda_o(u_i2c_link_if.dev_sda_o), .dev_sda_oe(u_i2c_link_if.dev_sda_oe),
    .scl(u_i2c_link_if.scl), .sda(u_i2c_link_if.sda));

  // 250 MHz clock
  always #2 core_clk_i = ~core_clk_i;

  // Hang guard, well above the expected run length
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("mismatches %0d of %0d checks", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic q();
    repeat (BQ) @(posedge core_clk_i);
  endtask

  // One bit slot driven by the bench in the master's place
  task automatic bb_bit(input logic b, output logic s);
    u_link_b.host_sda_oe <= ~b;
    q();
    u_link_b.host_scl_oe <= 1'b0;
    q();
    s = u_link_b.sda;
    q();
    u_link_b.host_scl_oe <= 1'b1;
    q();
  endtask

  task automatic bb_wr(input logic [7:0] v, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--)
      bb_bit(v[i], s);
    bb_bit(1'b1, s);
    a = ~s;
  endtask

  task automatic bb_rd(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bb_bit(1'b1, d[i]);
    bb_bit(~mack, s);
  endtask

  // Works from idle and as a repeated start
  task automatic bb_start();
    u_link_b.host_sda_oe <= 1'b0;
    q();
    u_link_b.host_scl_oe <= 1'b0;
    q();
    u_link_b.host_sda_oe <= 1'b1;
    q();
    u_link_b.host_scl_oe <= 1'b1;
    q();
  endtask

  task automatic bb_stop();
    u_link_b.host_sda_oe <= 1'b1;
    q();
    u_link_b.host_scl_oe <= 1'b0;
    q();
    u_link_b.host_sda_oe <= 1'b0;
    q();
  endtask

  // One command through the master, response checked
  task automatic do_cmd(input logic r_i, input logic [7:0] r, d, exp, input logic nk);
    @(posedge core_clk_i);
    cmd_valid <= 1'b1;
    cmd_read  <= r_i;
    cmd_reg   <= r;
    cmd_data  <= d;
    @(posedge core_clk_i);
    while (cmd_ready !== 1'b1)
      @(posedge core_clk_i);
    cmd_valid <= 1'b0;
    while (rsp_valid !== 1'b1)
      @(posedge core_clk_i);
    check(rsp_nack, nk);
    if (r_i)
      check(rsp_data, exp);
    rsp_ready <= 1'b1;
    @(posedge core_clk_i);
    rsp_ready <= 1'b0;
  endtask

  task automatic pop(input logic [7:0] a, d);
    check({wr_valid, wr_addr, wr_data}, {1'b1, a, d});
    wr_rdy <= 1'b1;
    @(posedge core_clk_i);
    wr_rdy <= 1'b0;
    @(posedge core_clk_i);
  endtask

  // Main sequence
  initial
  begin
    u_link_b.host_scl_o  = 1'b0;
    u_link_b.host_sda_o  = 1'b0;
    u_link_b.host_scl_oe = 1'b0;
    u_link_b.host_sda_oe = 1'b0;
    repeat (8) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    // Writes fill the two-entry stream; the third is refused
    do_cmd(1'b0, 8'h05, 8'ha5, 8'h00, 1'b0);
    check(regs[8*5 +: 8], 8'ha5);
    do_cmd(1'b0, 8'h06, 8'h3c, 8'h00, 1'b0);
    do_cmd(1'b0, 8'h07, 8'h77, 8'h00, 1'b1);
    check(regs[8*7 +: 8], 8'h00);
    pop(8'h05, 8'ha5);
    pop(8'h06, 8'h3c);
    check(wr_valid, 1'b0);
    check(busy, 1'b0);
    wr_rdy <= 1'b1;
    // Read back through repeated start, then past the file
    do_cmd(1'b1, 8'h05, 8'h00, 8'ha5, 1'b0);
    do_cmd(1'b1, 8'h06, 8'h00, 8'h3c, 1'b0);
    do_cmd(1'b1, 8'h40, 8'h00, 8'h00, 1'b0);
    // Only the exact key clears the file
    do_cmd(1'b0, 8'h14, 8'hfe, 8'h00, 1'b0);
    check(regs[8*5 +: 8], 8'ha5);
    do_cmd(1'b0, 8'h14, 8'hff, 8'h00, 1'b0);
    check(regs === '0, 1'b1);
    // Enable pin low disables the port and clears the file
    do_cmd(1'b0, 8'h03, 8'h5a, 8'h00, 1'b0);
    hw_en_n <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    check(regs === '0, 1'b1);
    do_cmd(1'b0, 8'h03, 8'h77, 8'h00, 1'b1);
    hw_en_n <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    check(regs[8*3 +: 8], 8'h00);
    // Burst write steps the pointer
    bb_start();
    bb_wr(8'h52, ack);
    check(ack, 1'b1);
    bb_wr(8'h08, ack);
    check(ack, 1'b1);
    for (int k = 1; k < 4; k++)
    begin
      bb_wr(8'(8'h11 * k), ack);
      check(ack, 1'b1);
    end
    check(busy_b, 1'b1);
    bb_stop();
    q();
    check(regs_b[8*8 +: 24], 24'h332211);
    check(busy_b, 1'b0);
    // Burst read over repeated start, closed by a refusal
    bb_start();
    bb_wr(8'h52, ack);
    bb_wr(8'h09, ack);
    bb_start();
    bb_wr(8'h53, ack);
    check(ack, 1'b1);
    bb_rd(1'b1, rd);
    check(rd, 8'h22);
    bb_rd(1'b0, rd);
    check(rd, 8'h33);
    bb_stop();
    check(u_link_b.dev_sda_oe, 1'b0);
    // Foreign address ignored, pointer left alone
    bb_start();
    bb_wr(8'h30, ack);
    check(ack, 1'b0);
    bb_wr(8'h0c, ack);
    check(ack, 1'b0);
    bb_stop();
    bb_start();
    bb_wr(8'h53, ack);
    bb_rd(1'b0, rd);
    check(rd, 8'h33);
    bb_stop();
    // Stop in mid byte abandons the write
    bb_start();
    bb_wr(8'h52, ack);
    bb_wr(8'h0c, ack);
    bb_bit(1'b1, ack);
    bb_bit(1'b0, ack);
    bb_stop();
    q();
    check(regs_b[8*12 +: 8], 8'h00);
    summarize();
  end
endmodule
